// [rtl/ser_pkg.sv]
// shared constants and carrier types of the status and event reporting block
package ser_pkg;
  // status byte bit positions
  localparam int SB_ERRQ = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_RQS = 6;
  localparam int SB_W = 8;
  // standard event bit positions
  localparam int EV_OPC = 0;
  localparam int EV_QYE = 2;
  localparam int EV_DDE = 3;
  localparam int EV_EXE = 4;
  localparam int EV_CME = 5;
  localparam int EV_PON = 7;
  // masks and fixed values
  localparam logic [7:0] SB_SUMMARY_MASK = 8'h3C;
  localparam logic [7:0] SB_RQS_EXCL_MASK = 8'hBF;
  localparam logic [7:0] REG_ZERO = 8'h00;
  localparam logic [7:0] EV_POR_VALUE = 8'h80;
  localparam logic [7:0] OPC_REPLY = 8'h31;
  localparam logic [15:0] ERRQ_OVF_CODE = 16'hFEA2;
  localparam logic [15:0] ERRQ_EMPTY_CODE = 16'h0000;
  localparam int ERRQ_DEPTH = 20;
  localparam int ERR_CODE_W = 16;

  // common commands from the host link
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_CLS = 4'h1,
    OP_RST = 4'h2,
    OP_ESE_WR = 4'h3,
    OP_ESE_RD = 4'h4,
    OP_ESR_RD = 4'h5,
    OP_SRE_WR = 4'h6,
    OP_SRE_RD = 4'h7,
    OP_STB_RD = 4'h8,
    OP_OPC = 4'h9,
    OP_OPC_RD = 4'hA,
    OP_ERR_RD = 4'hB
  } ser_op_t;

  typedef struct packed {
    logic valid;
    ser_op_t op;
    logic [7:0] arg;
  } ser_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ser_rsp_t;

  // one-cycle event pulses from the instrument
  typedef struct packed {
    logic oq_empty_read;
    logic oq_lost;
    logic oq_overflow;
    logic dev_err;
    logic exe_err;
    logic cmd_err;
  } ser_evt_t;

  // operation-complete tracking, one-hot
  typedef enum logic [2:0] {
    OPC_IDLE = 3'b001,
    OPC_WAIT_CMD = 3'b010,
    OPC_WAIT_QRY = 3'b100
  } ser_opc_st_t;
endpackage

// [rtl/ser_status.sv]
// status byte, standard event register, enables and error queue
`timescale 1ns/1ps
module ser_status #(
  parameter int ERRQ_DEPTH = ser_pkg::ERRQ_DEPTH,
  parameter int CODE_W = ser_pkg::ERR_CODE_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // host command link
  input wire ser_pkg::ser_cmd_t cmd,
  output ser_pkg::ser_rsp_t rsp,
  // instrument events and levels
  input wire ser_pkg::ser_evt_t evt,
  input wire logic ques_summary,
  input wire logic ops_busy,
  input wire logic oq_has_data,
  input wire logic oq_read,
  // error queue fill side
  input wire logic err_push,
  input wire logic [CODE_W-1:0] err_code,
  // status views and completion reply
  output logic [7:0] status_byte,
  output logic srq,
  output logic opc_reply_valid,
  output logic [7:0] opc_reply_data
);
  localparam int PW = (ERRQ_DEPTH > 1) ? $clog2(ERRQ_DEPTH) : 1;
  localparam int CW = $clog2(ERRQ_DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(ERRQ_DEPTH - 1);
  localparam logic [PW-1:0] PTR_ZERO = '0;
  localparam logic [PW-1:0] PTR_ONE = PW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(ERRQ_DEPTH);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  initial begin
    if (ERRQ_DEPTH < 2 || CODE_W < 16) begin
      $error("ser_status: unsupported queue depth or code width");
    end
  end

  logic [7:0] esr_q;
  logic [7:0] esr_d;
  logic [7:0] ese_q;
  logic [7:0] sre_q;
  logic mav_q;
  logic rqs_q;
  logic rqs_d;
  logic [CODE_W-1:0] errq_mem [ERRQ_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic ovf_lock_q;
  ser_pkg::ser_opc_st_t opc_st_q;
  ser_pkg::ser_rsp_t rsp_q;
  logic opc_reply_q;

  logic do_cls;
  logic do_esr_rd;
  logic do_stb_rd;
  logic errq_pop;
  logic errq_wr;
  logic errq_ovf;
  logic [7:0] ev_set;
  logic [7:0] stb_live;
  logic [PW-1:0] last_ptr;

  assign do_cls = cmd.valid && cmd.op == ser_pkg::OP_CLS;
  assign do_esr_rd = cmd.valid && cmd.op == ser_pkg::OP_ESR_RD;
  assign do_stb_rd = cmd.valid && cmd.op == ser_pkg::OP_STB_RD;

  // event sources into the standard event register
  always_comb begin
    ev_set = ser_pkg::REG_ZERO;
    ev_set[ser_pkg::EV_QYE] = evt.oq_empty_read | evt.oq_lost
                              | evt.oq_overflow;
    ev_set[ser_pkg::EV_DDE] = evt.dev_err;
    ev_set[ser_pkg::EV_EXE] = evt.exe_err;
    ev_set[ser_pkg::EV_CME] = evt.cmd_err;
    ev_set[ser_pkg::EV_OPC] = opc_st_q == ser_pkg::OPC_WAIT_CMD
                              && !ops_busy;
  end

  // a new event in the clearing cycle survives the clear
  always_comb begin
    esr_d = esr_q;
    if (do_cls || do_esr_rd) begin
      esr_d = ser_pkg::REG_ZERO;
    end
    esr_d = esr_d | ev_set;
  end

  // reset command has no path here; only power-up reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      esr_q <= ser_pkg::EV_POR_VALUE;
    end else begin
      esr_q <= esr_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ese_q <= ser_pkg::REG_ZERO;
    end else if (cmd.valid && cmd.op == ser_pkg::OP_ESE_WR) begin
      ese_q <= cmd.arg;
    end
  end

  // only an explicit write changes the service enable
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sre_q <= ser_pkg::REG_ZERO;
    end else if (cmd.valid && cmd.op == ser_pkg::OP_SRE_WR) begin
      sre_q <= cmd.arg;
    end
  end

  // data arriving while the host reads keeps the flag set
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mav_q <= 1'b0;
    end else if (oq_has_data && !oq_read) begin
      mav_q <= 1'b1;
    end else if (oq_read || do_cls || do_esr_rd) begin
      mav_q <= oq_has_data;
    end
  end

  // live status byte; unused bits stay zero
  always_comb begin
    stb_live = ser_pkg::REG_ZERO;
    stb_live[ser_pkg::SB_ERRQ] = cnt_q != CNT_ZERO;
    stb_live[ser_pkg::SB_QUES] = ques_summary;
    stb_live[ser_pkg::SB_MAV] = mav_q;
    stb_live[ser_pkg::SB_ESB] = |(esr_q & ese_q);
    stb_live[ser_pkg::SB_RQS] = rqs_q;
  end

  // clearing cycles win: sources are stale, a re-set follows next cycle
  always_comb begin
    rqs_d = rqs_q;
    if (do_stb_rd
        && (stb_live & ser_pkg::SB_SUMMARY_MASK) == 8'h00) begin
      rqs_d = 1'b0;
    end
    if ((stb_live & sre_q & ser_pkg::SB_RQS_EXCL_MASK) != 8'h00) begin
      rqs_d = 1'b1;
    end
    if (do_cls || do_esr_rd) begin
      rqs_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rqs_q <= 1'b0;
    end else begin
      rqs_q <= rqs_d;
    end
  end

  assign status_byte = stb_live;
  assign srq = rqs_q;

  // error queue: full queue turns its last entry into overflow
  assign errq_pop = cmd.valid && cmd.op == ser_pkg::OP_ERR_RD
                    && cnt_q != CNT_ZERO;
  assign errq_wr = err_push && !ovf_lock_q
                   && (cnt_q != CNT_FULL || errq_pop);
  assign errq_ovf = err_push && !ovf_lock_q && cnt_q == CNT_FULL
                    && !errq_pop;
  assign last_ptr = (wr_ptr_q == PTR_ZERO) ? PTR_LAST : wr_ptr_q - PTR_ONE;

  always_ff @(posedge ref_clk) begin
    if (errq_wr) begin
      errq_mem[wr_ptr_q] <= err_code;
    end else if (errq_ovf) begin
      errq_mem[last_ptr] <= CODE_W'(ser_pkg::ERRQ_OVF_CODE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b || do_cls) begin
      wr_ptr_q <= PTR_ZERO;
      rd_ptr_q <= PTR_ZERO;
      cnt_q <= CNT_ZERO;
    end else begin
      if (errq_wr) begin
        wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? PTR_ZERO : wr_ptr_q + PTR_ONE;
      end
      if (errq_pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? PTR_ZERO : rd_ptr_q + PTR_ONE;
      end
      if (errq_wr && !errq_pop) begin
        cnt_q <= cnt_q + CNT_ONE;
      end else if (errq_pop && !errq_wr) begin
        cnt_q <= cnt_q - CNT_ONE;
      end
    end
  end

  // no further entries until the queue drains or is cleared
  always_ff @(posedge ref_clk) begin
    if (!rst_b || do_cls) begin
      ovf_lock_q <= 1'b0;
    end else if (errq_ovf) begin
      ovf_lock_q <= 1'b1;
    end else if (cnt_q == CNT_ZERO) begin
      ovf_lock_q <= 1'b0;
    end
  end

  // operation-complete waits for all earlier work
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      opc_st_q <= ser_pkg::OPC_IDLE;
    end else begin
      case (opc_st_q)
        ser_pkg::OPC_IDLE: begin
          if (cmd.valid && cmd.op == ser_pkg::OP_OPC) begin
            opc_st_q <= ser_pkg::OPC_WAIT_CMD;
          end else if (cmd.valid && cmd.op == ser_pkg::OP_OPC_RD) begin
            opc_st_q <= ser_pkg::OPC_WAIT_QRY;
          end
        end
        ser_pkg::OPC_WAIT_CMD: begin
          if (!ops_busy) begin
            opc_st_q <= ser_pkg::OPC_IDLE;
          end
        end
        ser_pkg::OPC_WAIT_QRY: begin
          if (!ops_busy) begin
            opc_st_q <= ser_pkg::OPC_IDLE;
          end
        end
        default: begin
          opc_st_q <= ser_pkg::OPC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      opc_reply_q <= 1'b0;
    end else begin
      opc_reply_q <= opc_st_q == ser_pkg::OPC_WAIT_QRY && !ops_busy;
    end
  end

  assign opc_reply_valid = opc_reply_q;
  assign opc_reply_data = ser_pkg::OPC_REPLY;

  // query answers, one cycle after the command, pre-clear values
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= 1'b0;
      rsp_q.data <= '0;
      if (cmd.valid) begin
        case (cmd.op)
          ser_pkg::OP_ESE_RD: begin
            rsp_q.valid <= 1'b1;
            rsp_q.data <= {8'h00, ese_q};
          end
          ser_pkg::OP_ESR_RD: begin
            rsp_q.valid <= 1'b1;
            rsp_q.data <= {8'h00, esr_q};
          end
          ser_pkg::OP_SRE_RD: begin
            rsp_q.valid <= 1'b1;
            rsp_q.data <= {8'h00, sre_q};
          end
          ser_pkg::OP_STB_RD: begin
            rsp_q.valid <= 1'b1;
            rsp_q.data <= {8'h00, stb_live};
          end
          ser_pkg::OP_ERR_RD: begin
            rsp_q.valid <= 1'b1;
            rsp_q.data <= (cnt_q != CNT_ZERO) ? errq_mem[rd_ptr_q][15:0]
                          : ser_pkg::ERRQ_EMPTY_CODE;
          end
          default: begin
            rsp_q.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  assign rsp = rsp_q;

  // checks
  AST_PON: assert property (@(posedge ref_clk)
    $rose(rst_b) |-> esr_q[ser_pkg::EV_PON])
    else $error("power-on bit not set after reset");
  AST_ZERO_BITS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !status_byte[0] && !status_byte[1] && !status_byte[7]
    && !esr_q[1] && !esr_q[6])
    else $error("unused bit reads one");
  AST_ESR_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_esr_rd && ev_set == 8'h00 |=> esr_q == 8'h00)
    else $error("event register not cleared by read");
  AST_RST_KEEPS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cmd.valid && cmd.op == ser_pkg::OP_RST |=> (esr_q & $past(esr_q))
    == $past(esr_q))
    else $error("reset command cleared events");
  AST_ESB_SUM: assert property (@(posedge ref_clk) disable iff (!rst_b)
    evt.cmd_err && ese_q[ser_pkg::EV_CME]
    && !(cmd.valid && cmd.op == ser_pkg::OP_ESE_WR)
    |=> status_byte[ser_pkg::SB_ESB])
    else $error("event summary mismatch");
  AST_SRE_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cmd.valid && cmd.op == ser_pkg::OP_SRE_WR && cmd.arg == 8'h00
    |=> sre_q == 8'h00)
    else $error("service enable not cleared");
  AST_STB_ANSWER: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_stb_rd |=> rsp.valid && rsp.data[7:0] == $past(status_byte))
    else $error("status query answer wrong");
  AST_RQS_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_stb_rd && (status_byte & ser_pkg::SB_SUMMARY_MASK) == 8'h00
    && (status_byte & sre_q & ser_pkg::SB_RQS_EXCL_MASK) == 8'h00
    |=> !srq)
    else $error("request bit not cleared by idle query");
  AST_OPC_SET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    opc_st_q == ser_pkg::OPC_WAIT_CMD && !ops_busy
    |=> esr_q[ser_pkg::EV_OPC] && opc_st_q == ser_pkg::OPC_IDLE)
    else $error("operation complete not flagged");
  AST_OPC_QUERY: assert property (@(posedge ref_clk) disable iff (!rst_b)
    opc_st_q == ser_pkg::OPC_WAIT_QRY && !ops_busy
    |=> opc_reply_valid && !$rose(esr_q[ser_pkg::EV_OPC]))
    else $error("completion query misbehaved");
  AST_ERRQ_BIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    status_byte[ser_pkg::SB_ERRQ] == (cnt_q != CNT_ZERO)
    && cnt_q <= CNT_FULL)
    else $error("error queue bit or count wrong");

  COV_SRQ: cover property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(srq));
  COV_ERRQ_FULL: cover property (@(posedge ref_clk) disable iff (!rst_b)
    errq_ovf);
  COV_OPC_REPLY: cover property (@(posedge ref_clk) disable iff (!rst_b)
    opc_reply_valid);
endmodule // ser_status

// [tb/ser_host_model.sv]
// host controller model issuing common commands on the link
`timescale 1ns/1ps
module ser_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // idle edges before each command on top of one fixed edge, 0..3
  input wire logic [1:0] gap,
  // command link
  output ser_pkg::ser_cmd_t cmd
);
  initial cmd = '0;

  // one-cycle strobe; the idle edge after it keeps strobes apart
  // late reports a reset that never ended; nothing is driven then
  task automatic send(input ser_pkg::ser_op_t op, input logic [7:0] arg,
                      output logic late);
    int k;
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    for (k = 0; k < 32 && rst_b !== 1'b1; k++) @(posedge ref_clk);
    late = (rst_b !== 1'b1);
    if (!late) begin
      cmd <= '{valid: 1'b1, op: op, arg: arg};
      @(posedge ref_clk);
      cmd <= '0;
    end
  endtask
endmodule // ser_host_model

// [tb/tb_status_event_reporting.sv]
// self-checking bench of the status and event reporting block
`timescale 1ns/1ps
module tb_status_event_reporting;
  logic ref_clk;
  logic rst_b;
  ser_pkg::ser_cmd_t cmd;
  ser_pkg::ser_rsp_t rsp;
  ser_pkg::ser_evt_t evt;
  logic ques_summary, ops_busy, oq_has_data, oq_read, err_push;
  logic [15:0] err_code;
  logic [7:0] status_byte;
  logic srq, opc_reply_valid;
  logic [7:0] opc_reply_data;
  logic [1:0] gap;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  logic [15:0] eq[$];
  int n_fail, tests_run, n_opc;

  ser_status i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd),
    .rsp(rsp), .evt(evt), .ques_summary(ques_summary),
    .ops_busy(ops_busy), .oq_has_data(oq_has_data), .oq_read(oq_read),
    .err_push(err_push), .err_code(err_code), .status_byte(status_byte),
    .srq(srq), .opc_reply_valid(opc_reply_valid),
    .opc_reply_data(opc_reply_data));
  ser_host_model i_host (.ref_clk(ref_clk), .rst_b(rst_b), .gap(gap),
    .cmd(cmd));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // random spacing so answers also meet slow command streams
  task automatic wr(input ser_pkg::ser_op_t op, input logic [7:0] a);
    logic late;
    seed = lfsr(seed);
    gap = seed[1:0];
    i_host.send(op, a, late);
    if (late) begin
      chk({15'h0000, late}, 16'h0000);
      complete_run();
    end
  endtask

  task automatic q(input ser_pkg::ser_op_t op, input logic [15:0] exp);
    exp_q.push_back(exp);
    wr(op, 8'h00);
  endtask

  task automatic pulse(input logic [5:0] w);
    @(posedge ref_clk);
    evt <= w;
    @(posedge ref_clk);
    evt <= '0;
  endtask

  // live byte checked mid-cycle; returns on a rising edge
  task automatic st(input logic [7:0] exp);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({8'h00, status_byte}, {8'h00, exp});
    chk({15'h0000, srq}, {15'h0000, exp[6]});
    @(posedge ref_clk);
  endtask

  task automatic endt(input string s);
    int k;
    for (k = 0; k < 50 && exp_q.size() != 0; k++) @(posedge ref_clk);
    if (exp_q.size() != 0) begin
      chk(16'(exp_q.size()), 16'h0000);
      complete_run();
    end else begin
      $display("test %s done", s);
    end
  endtask

  always @(posedge ref_clk) begin
    if (opc_reply_valid === 1'b1) begin
      n_opc++;
    end
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("mismatch at %0t: unexpected answer", $time);
      end else begin
        chk(rsp.data, exp_q.pop_front());
      end
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    int i;
    int k;
    logic [7:0] w;
    rst_b = 1'b0;
    evt = '0;
    ques_summary = 1'b0;
    ops_busy = 1'b0;
    oq_has_data = 1'b0;
    oq_read = 1'b0;
    err_push = 1'b0;
    err_code = 16'h0000;
    gap = 2'h0;
    seed = 32'h0000_3887;
    n_fail = 0;
    tests_run = 0;
    n_opc = 0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    q(ser_pkg::OP_ESR_RD, 16'h0080);
    q(ser_pkg::OP_ESR_RD, 16'h0000);
    q(ser_pkg::OP_ESE_RD, 16'h0000);
    q(ser_pkg::OP_SRE_RD, 16'h0000);
    q(ser_pkg::OP_STB_RD, 16'h0000);
    endt("power_up");
    for (i = 0; i < 6; i++) begin
      w = (i < 3) ? (8'h20 >> i) : 8'h04;
      pulse(6'(1 << i));
      wr(ser_pkg::OP_RST, 8'h00);
      q(ser_pkg::OP_ESR_RD, {8'h00, w});
      q(ser_pkg::OP_ESR_RD, 16'h0000);
    end
    endt("event_bits");
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      w = {seed[7:6], i[0], seed[4:0]};
      wr(ser_pkg::OP_ESE_WR, w);
      q(ser_pkg::OP_ESE_RD, {8'h00, w});
      pulse(6'h01);
      st({2'b00, w[5], 5'b00000});
      q(ser_pkg::OP_ESR_RD, 16'h0020);
      st(8'h00);
    end
    wr(ser_pkg::OP_ESE_WR, 8'h00);
    q(ser_pkg::OP_ESE_RD, 16'h0000);
    endt("event_enable");
    wr(ser_pkg::OP_SRE_WR, 8'h10);
    oq_has_data <= 1'b1;
    st(8'h50);
    q(ser_pkg::OP_STB_RD, 16'h0050);
    st(8'h50);
    oq_has_data <= 1'b0;
    oq_read <= 1'b1;
    @(posedge ref_clk);
    oq_read <= 1'b0;
    st(8'h40);
    q(ser_pkg::OP_STB_RD, 16'h0040);
    st(8'h00);
    ques_summary <= 1'b1;
    st(8'h08);
    ques_summary <= 1'b0;
    q(ser_pkg::OP_SRE_RD, 16'h0010);
    wr(ser_pkg::OP_SRE_WR, 8'h00);
    q(ser_pkg::OP_SRE_RD, 16'h0000);
    endt("service_request");
    // two pushes past full: one turns into overflow, one is dropped
    for (i = 0; i < 22; i++) begin
      seed = lfsr(seed);
      err_push <= 1'b1;
      err_code <= seed[15:0];
      if (i < 19) eq.push_back(seed[15:0]);
      @(posedge ref_clk);
    end
    err_push <= 1'b0;
    eq.push_back(ser_pkg::ERRQ_OVF_CODE);
    st(8'h04);
    for (i = 0; i < 20; i++) q(ser_pkg::OP_ERR_RD, eq.pop_front());
    q(ser_pkg::OP_ERR_RD, 16'h0000);
    st(8'h00);
    endt("error_queue");
    ops_busy <= 1'b1;
    wr(ser_pkg::OP_OPC, 8'h00);
    st(8'h00);
    q(ser_pkg::OP_ESR_RD, 16'h0000);
    ops_busy <= 1'b0;
    st(8'h00);
    q(ser_pkg::OP_ESR_RD, 16'h0001);
    ops_busy <= 1'b1;
    wr(ser_pkg::OP_OPC_RD, 8'h00);
    st(8'h00);
    chk(16'(n_opc), 16'h0000);
    ops_busy <= 1'b0;
    for (k = 0; k < 8 && opc_reply_valid !== 1'b1; k++) @(posedge ref_clk);
    if (opc_reply_valid !== 1'b1) begin
      chk({15'h0000, opc_reply_valid}, 16'h0001);
      complete_run();
    end
    chk({8'h00, opc_reply_data}, 16'h0031);
    q(ser_pkg::OP_ESR_RD, 16'h0000);
    endt("completion");
    chk(16'(n_opc), 16'h0001);
    pulse(6'h02);
    err_push <= 1'b1;
    err_code <= 16'h1234;
    @(posedge ref_clk);
    err_push <= 1'b0;
    wr(ser_pkg::OP_SRE_WR, 8'h24);
    st(8'h44);
    wr(ser_pkg::OP_CLS, 8'h00);
    st(8'h00);
    q(ser_pkg::OP_ESR_RD, 16'h0000);
    q(ser_pkg::OP_ERR_RD, 16'h0000);
    q(ser_pkg::OP_SRE_RD, 16'h0024);
    endt("clear_status");
    complete_run();
  end
endmodule // tb_status_event_reporting
